// ---- pkg/hpm_pkg.sv ----
package hpm_pkg;
    // master indices
    localparam int NUM_MASTERS = 3;
    localparam int MST_MAIN_CPU = 0;
    localparam int MST_SYS_DMA = 1;
    localparam int MST_PERIPH_TC = 2;
    // slave indices
    localparam int NUM_SLAVES = 3;
    localparam int SLV_SHARED_SRAM0 = 0;
    localparam int SLV_SRAM_UPPER = 1;
    localparam int SLV_PERIPH = 2;
    localparam int SLV_NONE = 3;
    // address map: base and mask per slave region, base and limit for the upper sram
    localparam logic [31:0] SRAM0_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM0_MASK = 32'hfffe_0000;
    localparam logic [31:0] SRAM_UP_BASE = 32'h2002_0000;
    localparam logic [31:0] SRAM_UP_LIMIT = 32'h2007_ffff;
    localparam logic [31:0] PERIPH_BASE = 32'h5000_0000;
    localparam logic [31:0] PERIPH_MASK = 32'hfffc_0000;
    // connectivity: bit m of row s set when master m may reach slave s
    localparam logic [2:0] CONN_SRAM0 = 3'h7;
    localparam logic [2:0] CONN_SRAM_UP = 3'h7;
    localparam logic [2:0] CONN_PERIPH = 3'h7;
    // ahb transfer and response codes
    localparam logic [1:0] HTRANS_IDLE = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HRESP_OKAY = 2'h0;
    localparam logic [1:0] HRESP_ERROR = 2'h1;
    typedef enum logic [1:0] {
        HPM_ERR_IDLE = 2'b00,
        HPM_ERR_FIRST = 2'b01,
        HPM_ERR_SECOND = 2'b10
    } hpm_err_t;
endpackage

// ---- verilog/hpm_rr_arb.sv ----
`timescale 1ns/1ps
module hpm_rr_arb
    import hpm_pkg::*;
#(
    parameter int N = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // requests and control
    input wire logic [N-1:0] req,
    input wire logic advance,
    // one-hot grant
    output logic [N-1:0] grant
);
    logic [N-1:0] prio_r;
    logic [N-1:0] prio_nxt;

    // pick the first requester at or after the priority pointer
    always_comb begin
        logic found;
        grant = '0;
        found = 1'b0;
        // scan from pointer position; simple and bounded
        for (int j = 0; j < N; j++) begin
            for (int i = 0; i < N; i++) begin
                if (!found && prio_r[j] && req[(i + j) % N]) begin
                    grant[(i + j) % N] = 1'b1;
                    found = 1'b1;
                end
            end
        end
    end

    // pointer moves past the granted master only when a grant is taken
    always_comb begin
        prio_nxt = prio_r;
        if (advance && |grant) begin
            prio_nxt = {grant[N-2:0], grant[N-1]};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prio_r <= {{(N-1){1'b0}}, 1'b1};
        end else begin
            prio_r <= prio_nxt;
        end
    end
endmodule

// ---- verilog/hpm_bus_matrix.sv ----
`timescale 1ns/1ps
module hpm_bus_matrix
    import hpm_pkg::*;
#(
    parameter int NM = NUM_MASTERS,
    parameter int NS = NUM_SLAVES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // master side ahb ports, one lane per master
    input wire logic [NM-1:0][31:0] m_haddr,
    input wire logic [NM-1:0][1:0] m_htrans,
    input wire logic [NM-1:0] m_hwrite,
    input wire logic [NM-1:0][2:0] m_hsize,
    input wire logic [NM-1:0][31:0] m_hwdata,
    output logic [NM-1:0][31:0] m_hrdata,
    output logic [NM-1:0] m_hready,
    output logic [NM-1:0][1:0] m_hresp,
    // slave side ahb ports, one lane per slave region
    output logic [NS-1:0] s_hsel,
    output logic [NS-1:0][31:0] s_haddr,
    output logic [NS-1:0][1:0] s_htrans,
    output logic [NS-1:0] s_hwrite,
    output logic [NS-1:0][2:0] s_hsize,
    output logic [NS-1:0][31:0] s_hwdata,
    input wire logic [NS-1:0][31:0] s_hrdata,
    input wire logic [NS-1:0] s_hreadyout,
    input wire logic [NS-1:0][1:0] s_hresp
);
    localparam logic [NS-1:0][NM-1:0] CONN = {CONN_PERIPH, CONN_SRAM_UP,
                                              CONN_SRAM0};

    // per master: decoded target, address phase hold and data phase owner
    logic [NM-1:0][1:0] tgt;
    logic [NM-1:0] m_req;
    logic [NM-1:0] hold_r, hold_nxt;
    logic [NM-1:0][31:0] hadr_r, hadr_nxt;
    logic [NM-1:0][1:0] htr_r, htr_nxt;
    logic [NM-1:0] hwr_r, hwr_nxt;
    logic [NM-1:0][2:0] hsz_r, hsz_nxt;
    logic [NM-1:0] dph_r, dph_nxt;
    logic [NM-1:0][1:0] dslv_r, dslv_nxt;
    logic [NM-1:0] m_dok;
    hpm_err_t [NM-1:0] err_r, err_nxt;
    // per slave: address owner and data phase owner
    logic [NS-1:0][NM-1:0] sreq, sgnt;
    logic [NS-1:0][NM-1:0] aown;
    logic [NS-1:0][NM-1:0] down_r, down_nxt;
    logic [NS-1:0] sbusy;

    // effective request: held copy while waiting, else live bus
    function automatic logic [1:0] decode(input logic [31:0] a);
        if ((a & SRAM0_MASK) == SRAM0_BASE) begin
            decode = 2'(SLV_SHARED_SRAM0);
        end else if (a >= SRAM_UP_BASE && a <= SRAM_UP_LIMIT) begin
            decode = 2'(SLV_SRAM_UPPER);
        end else if ((a & PERIPH_MASK) == PERIPH_BASE) begin
            decode = 2'(SLV_PERIPH);
        end else begin
            decode = 2'(SLV_NONE);
        end
    endfunction

    logic [NM-1:0][31:0] ea;
    logic [NM-1:0][1:0] et;
    logic [NM-1:0] ew;
    logic [NM-1:0][2:0] ez;

    genvar gm, gs;
    generate
        for (gm = 0; gm < NM; gm++) begin : g_m
            assign ea[gm] = hold_r[gm] ? hadr_r[gm] : m_haddr[gm];
            assign et[gm] = hold_r[gm] ? htr_r[gm] : m_htrans[gm];
            assign ew[gm] = hold_r[gm] ? hwr_r[gm] : m_hwrite[gm];
            assign ez[gm] = hold_r[gm] ? hsz_r[gm] : m_hsize[gm];
            assign tgt[gm] = decode(ea[gm]);
            // a live address counts only once this master's data phase ends,
            // so a stalled master never gets its next address taken early
            assign m_dok[gm] = err_r[gm] != HPM_ERR_FIRST &&
                               (!dph_r[gm] || s_hreadyout[dslv_r[gm]]);
            assign m_req[gm] = et[gm][1] && (hold_r[gm] || m_dok[gm]);
        end
        // one arbiter per slave keeps slaves independent
        for (gs = 0; gs < NS; gs++) begin : g_s
            for (gm = 0; gm < NM; gm++) begin : g_r
                // unconnected masters never reach the arbiter
                assign sreq[gs][gm] = m_req[gm] && tgt[gm] == 2'(gs) &&
                                      CONN[gs][gm];
            end
            // busy while a data phase stalls on this slave
            assign sbusy[gs] = |down_r[gs] && !s_hreadyout[gs];
            hpm_rr_arb #(.N(NM)) u_arb (
                .clk(clk),
                .rst_n(rst_n),
                .req(sreq[gs]),
                .advance(!sbusy[gs]),
                .grant(sgnt[gs])
            );
            assign aown[gs] = sbusy[gs] ? '0 : sgnt[gs];
        end
    endgenerate

    // slave lane muxes: each slave driven only by its own owner
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            s_hsel[s] = |aown[s];
            s_haddr[s] = '0;
            s_htrans[s] = HTRANS_IDLE;
            s_hwrite[s] = 1'b0;
            s_hsize[s] = '0;
            s_hwdata[s] = '0;
            for (int m = 0; m < NM; m++) begin
                if (aown[s][m]) begin
                    s_haddr[s] = ea[m];
                    s_htrans[s] = HTRANS_NONSEQ;
                    s_hwrite[s] = ew[m];
                    s_hsize[s] = ez[m];
                end
                if (down_r[s][m]) begin
                    s_hwdata[s] = m_hwdata[m];
                end
            end
        end
    end

    // master side: waits only on its own slave, never on others
    always_comb begin
        logic took;
        logic ok;
        took = 1'b0;
        ok = 1'b1;
        for (int m = 0; m < NM; m++) begin
            took = 1'b0;
            for (int s = 0; s < NS; s++) begin
                if (aown[s][m]) begin
                    took = 1'b1;
                end
            end
            // data phase ready comes from the addressed slave alone
            ok = 1'b1;
            m_hrdata[m] = '0;
            m_hresp[m] = HRESP_OKAY;
            if (err_r[m] == HPM_ERR_FIRST) begin
                ok = 1'b0;
                m_hresp[m] = HRESP_ERROR;
            end else if (err_r[m] == HPM_ERR_SECOND) begin
                m_hresp[m] = HRESP_ERROR;
            end else if (dph_r[m]) begin
                ok = s_hreadyout[dslv_r[m]];
                m_hrdata[m] = s_hrdata[dslv_r[m]];
                m_hresp[m] = s_hresp[dslv_r[m]];
            end
            // a lost arbitration is held and replayed; the master waits
            // until the replayed address has had its own data phase
            m_hready[m] = ok && !hold_r[m];
            hold_nxt[m] = 1'b0;
            hadr_nxt[m] = hadr_r[m];
            htr_nxt[m] = htr_r[m];
            hwr_nxt[m] = hwr_r[m];
            hsz_nxt[m] = hsz_r[m];
            dph_nxt[m] = dph_r[m];
            dslv_nxt[m] = dslv_r[m];
            err_nxt[m] = err_r[m] == HPM_ERR_FIRST ? HPM_ERR_SECOND :
                         HPM_ERR_IDLE;
            if (ok) begin
                dph_nxt[m] = took;
                if (took) begin
                    dslv_nxt[m] = tgt[m];
                end
                if (m_req[m] && !took) begin
                    if (tgt[m] == 2'(SLV_NONE) ||
                            !CONN[tgt[m]][m]) begin
                        err_nxt[m] = HPM_ERR_FIRST;
                    end else begin
                        hold_nxt[m] = 1'b1;
                        hadr_nxt[m] = ea[m];
                        htr_nxt[m] = et[m];
                        hwr_nxt[m] = ew[m];
                        hsz_nxt[m] = ez[m];
                    end
                end
            end else begin
                hold_nxt[m] = hold_r[m];
            end
        end
    end

    // data phase ownership per slave follows an accepted address phase
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            down_nxt[s] = down_r[s];
            if (!sbusy[s]) begin
                down_nxt[s] = aown[s];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_r <= '0;
            hadr_r <= '0;
            htr_r <= '0;
            hwr_r <= '0;
            hsz_r <= '0;
            dph_r <= '0;
            dslv_r <= '0;
            err_r <= '{default: HPM_ERR_IDLE};
            down_r <= '0;
        end else begin
            hold_r <= hold_nxt;
            hadr_r <= hadr_nxt;
            htr_r <= htr_nxt;
            hwr_r <= hwr_nxt;
            hsz_r <= hsz_nxt;
            dph_r <= dph_nxt;
            dslv_r <= dslv_nxt;
            err_r <= err_nxt;
            down_r <= down_nxt;
        end
    end
endmodule

// ---- verif/hpm_slv_model.sv ----
`timescale 1ns/1ps
module hpm_slv_model
    import hpm_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // ahb slave lane
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic [1:0] hresp,
    // one wait state per transfer when set
    input wire logic slow
);
    logic [31:0] mem [16];
    logic act_r;
    logic wr_r;
    logic wt_r;
    logic [3:0] ix_r;
    // zero wait unless the bench asks for a slow lane
    assign hreadyout = !(act_r && wt_r);
    assign hresp = HRESP_OKAY;
    // outside a read data phase show the inverse, so stale data never passes
    assign hrdata = (act_r && !wr_r) ? mem[ix_r] : ~mem[ix_r];
    // address taken only while the lane is ready
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            act_r <= 1'b0;
            wt_r <= 1'b0;
        end else if (hreadyout) begin
            if (act_r && wr_r) begin
                mem[ix_r] <= hwdata;
            end
            act_r <= hsel && htrans[1];
            wt_r <= slow;
            wr_r <= hwrite;
            ix_r <= haddr[5:2];
        end else begin
            wt_r <= 1'b0;
        end
    end
endmodule

// ---- verif/hpm_bus_matrix_chk.sv ----
`timescale 1ns/1ps
module hpm_bus_matrix_chk
    import hpm_pkg::*;
#(
    parameter int NM = 3,
    parameter int NS = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // master side
    input wire logic [NM-1:0][31:0] m_haddr,
    input wire logic [NM-1:0][1:0] m_htrans,
    input wire logic [NM-1:0] m_hwrite,
    input wire logic [NM-1:0][31:0] m_hrdata,
    input wire logic [NM-1:0] m_hready,
    // slave side
    input wire logic [NS-1:0] s_hsel,
    input wire logic [NS-1:0][31:0] s_haddr,
    input wire logic [NS-1:0][31:0] s_hrdata,
    input wire logic [NS-1:0] s_hreadyout
);
    logic [2:0] to0;
    logic [2:0] to1;
    logic [2:0] to2;
    // which slave each master is asking for
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            to0[i] = m_htrans[i][1] && m_haddr[i][31:17] == 15'h1000;
            to1[i] = m_htrans[i][1] && m_haddr[i][31:19] == 13'h0400
                && m_haddr[i][18:17] != 2'h0;
            to2[i] = m_htrans[i][1] && m_haddr[i][31:18] == 14'h1400;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_sel_sram0;
        s_hsel[0] |-> s_haddr[0][31:17] == 15'h1000;
    endproperty
    a_sel_sram0: assert property (p_sel_sram0)
        else $error("bank0 lane selected outside its window");
    property p_sel_periph;
        s_hsel[2] |-> s_haddr[2][31:18] == 14'h1400;
    endproperty
    a_sel_periph: assert property (p_sel_periph)
        else $error("peripheral lane selected outside its window");
    property p_cpu_route;
        to0[0] && m_hready[0] && to0[2:1] == 2'h0 && s_hreadyout[0]
            |-> s_hsel[0] && s_haddr[0] == m_haddr[0];
    endproperty
    a_cpu_route: assert property (p_cpu_route)
        else $error("lone cpu request not routed to bank0");
    property p_dma_route;
        to1[1] && m_hready[1] && !to1[0] && !to1[2] && s_hreadyout[1]
            |-> s_hsel[1] && s_haddr[1] == m_haddr[1];
    endproperty
    a_dma_route: assert property (p_dma_route)
        else $error("lone dma request not routed to upper sram");
    property p_contend;
        to0[0] && to0[1] && m_hready[1:0] == 2'h3
            |=> m_hready[1:0] != 2'h3;
    endproperty
    a_contend: assert property (p_contend)
        else $error("two masters served by one slave at once");
    property p_wait_bound;
        !m_hready[1] |-> ##[0:6] m_hready[1];
    endproperty
    a_wait_bound: assert property (p_wait_bound)
        else $error("held dma request never served");
    property p_no_stall;
        to2[2] && m_hready[2] && to2[1:0] == 2'h0
            |=> m_hready[2] == s_hreadyout[2];
    endproperty
    a_no_stall: assert property (p_no_stall)
        else $error("task controller stalled by foreign traffic");
    property p_rd_fwd;
        to0[1] && !m_hwrite[1] && m_hready[1] && !to0[0] && !to0[2]
            && s_hreadyout[0] |=> m_hready[1] == s_hreadyout[0]
            && (!m_hready[1] || m_hrdata[1] == s_hrdata[0]);
    endproperty
    a_rd_fwd: assert property (p_rd_fwd)
        else $error("dma read of bank0 not forwarded");
endmodule
bind hpm_bus_matrix hpm_bus_matrix_chk #(.NM(NM), .NS(NS)) chk_u (
    .clk(clk), .rst_n(rst_n), .m_haddr(m_haddr), .m_htrans(m_htrans),
    .m_hwrite(m_hwrite), .m_hrdata(m_hrdata), .m_hready(m_hready),
    .s_hsel(s_hsel), .s_haddr(s_haddr), .s_hrdata(s_hrdata),
    .s_hreadyout(s_hreadyout));

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench
    import hpm_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0][31:0] m_haddr = '0;
    logic [2:0][1:0] m_htrans = '0;
    logic [2:0] m_hwrite = '0;
    logic [2:0][2:0] m_hsize = {3{3'h2}};
    logic [2:0][31:0] m_hwdata = '0;
    logic [2:0][31:0] m_hrdata;
    logic [2:0] m_hready;
    logic [2:0][1:0] m_hresp;
    logic [2:0] s_hsel;
    logic [2:0][31:0] s_haddr;
    logic [2:0][1:0] s_htrans;
    logic [2:0] s_hwrite;
    logic [2:0][2:0] s_hsize;
    logic [2:0][31:0] s_hwdata;
    logic [2:0][31:0] s_hrdata;
    logic [2:0] s_hreadyout;
    logic [2:0][1:0] s_hresp;
    logic [2:0] slow = '0;
    logic [31:0] rdv [3];
    logic [1:0] rsp [3];
    int nw [3];
    int mismatches = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    hpm_bus_matrix dut_u (.clk(clk), .rst_n(rst_n), .m_haddr(m_haddr),
        .m_htrans(m_htrans), .m_hwrite(m_hwrite), .m_hsize(m_hsize),
        .m_hwdata(m_hwdata), .m_hrdata(m_hrdata), .m_hready(m_hready),
        .m_hresp(m_hresp), .s_hsel(s_hsel), .s_haddr(s_haddr),
        .s_htrans(s_htrans), .s_hwrite(s_hwrite), .s_hsize(s_hsize),
        .s_hwdata(s_hwdata), .s_hrdata(s_hrdata),
        .s_hreadyout(s_hreadyout), .s_hresp(s_hresp));
    // one slave model per lane
    for (genvar s = 0; s < 3; s++) begin : g_slv
        hpm_slv_model slv_u (.clk(clk), .rst_n(rst_n), .hsel(s_hsel[s]),
            .haddr(s_haddr[s]), .htrans(s_htrans[s]),
            .hwrite(s_hwrite[s]), .hwdata(s_hwdata[s]),
            .hrdata(s_hrdata[s]), .hreadyout(s_hreadyout[s]),
            .hresp(s_hresp[s]), .slow(slow[s]));
    end
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_sim();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    // one ahb step: sample ready at the falling edge, half a cycle before the rising edge, release 1 ns after it
    task automatic step(input int m);
        logic ok;
        do begin
            @(negedge clk);
            ok = m_hready[m];
            rdv[m] = m_hrdata[m];
            rsp[m] = m_hresp[m];
            @(posedge clk);
            #1;
            if (ok !== 1'b1) nw[m]++;
        end while (ok !== 1'b1 && cycles < 2000);
    endtask
    task automatic xfer(input int m, input logic [31:0] a,
            input logic w, input logic [31:0] d);
        nw[m] = 0;
        m_haddr[m] = a;
        m_htrans[m] = HTRANS_NONSEQ;
        m_hwrite[m] = w;
        step(m);
        m_htrans[m] = HTRANS_IDLE;
        m_hwdata[m] = d;
        step(m);
    endtask
    // three masters on three slaves at once, then crosswise read back
    task s_parallel;
        fork
            xfer(0, SRAM0_BASE + 32'h4, 1'b1, 32'h11);
            xfer(1, SRAM_UP_BASE + 32'h8, 1'b1, 32'h22);
            xfer(2, PERIPH_BASE + 32'hc, 1'b1, 32'h33);
        join
        for (int i = 0; i < 3; i++) begin
            chk("parallel waits", 32'(nw[i]), 32'h0);
        end
        fork
            xfer(1, SRAM0_BASE + 32'h4, 1'b0, 32'h0);
            xfer(2, SRAM_UP_BASE + 32'h8, 1'b0, 32'h0);
            xfer(0, PERIPH_BASE + 32'hc, 1'b0, 32'h0);
        join
        chk("dma bank0 read", rdv[1], 32'h11);
        chk("ptc sram read", rdv[2], 32'h22);
        chk("cpu periph read", rdv[0], 32'h33);
    endtask
    // chosen masters race for bank0; waits give the service order
    task automatic s_race(input logic [2:0] who, input int e0, e1, e2);
        int e [3];
        e = '{e0, e1, e2};
        for (int i = 0; i < 3; i++) begin
            automatic int k = i;
            if (who[k]) begin
                fork
                    xfer(k, SRAM0_BASE + 32'(16 + 4 * k), 1'b1, 32'(k));
                join_none
            end
        end
        wait fork;
        for (int i = 0; i < 3; i++) begin
            if (who[i]) chk("race waits", 32'(nw[i]), 32'(e[i]));
        end
    endtask
    // slow bank0 must not hold back the upper sram
    task s_slow;
        slow[0] = 1'b1;
        fork
            xfer(0, SRAM0_BASE + 32'h20, 1'b1, 32'h66);
            xfer(1, SRAM_UP_BASE + 32'h20, 1'b1, 32'h77);
        join
        chk("slow lane waits", 32'(nw[0]), 32'h1);
        chk("fast lane waits", 32'(nw[1]), 32'h0);
        s_race(3'b011, 3, 1, 0);
        slow[0] = 1'b0;
    endtask
    // lane carries the master's size; unmapped address gets the error pair
    task s_err_size;
        m_hsize[2] = 3'h1;
        m_haddr[2] = PERIPH_BASE + 32'h10;
        m_htrans[2] = HTRANS_NONSEQ;
        @(negedge clk);
        chk("lane size", 32'(s_hsize[2]), 32'h1);
        chk("lane select", 32'(s_hsel[2]), 32'h1);
        @(posedge clk);
        #1;
        m_htrans[2] = HTRANS_IDLE;
        m_hsize[2] = 3'h2;
        step(2);
        xfer(2, 32'h3000_0000, 1'b0, 32'h0);
        chk("unmapped waits", 32'(nw[2]), 32'h1);
        chk("unmapped resp", 32'(rsp[2]), 32'(HRESP_ERROR));
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1;
        rst_n = 1'b1;
        s_parallel();
        s_race(3'b011, 0, 1, 0);
        s_race(3'b110, 0, 1, 0);
        s_race(3'b111, 1, 2, 0);
        s_slow();
        s_err_size();
        end_sim();
    end
endmodule
